// File: shared/mpc_map.svh
// Address, field, index and reset constants of the memory protection checker.
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH
`define SEG_MSB 31
`define SEG_LSB 28
`define SEG_PRIV_FIRST 4'hE
`define SEG_SYSTEM 4'hF
`define PAGE_BITS 12
`define FRAME_BITS 20
`define SETS 4
`define RANGES 6
`define DATA_RANGES 4
`define MODE_BITS 3
`define MODE_EN 0
`define MODE_RD 1
`define MODE_WR 2
`define MODE_EX 1
`define ITEM_BOUNDS 5'h0C
`define ITEM_MODE 5'h0C
`define BOUND_RST 32'h0000_0000
`define MODE_RST 18'h0_0000
`define MAP_EXC_END 32'hF03F_FFFF
`define MAP_OPEN1_END 32'hF04F_FFFF
`define MAP_RES1_END 32'hF0FF_FFFF
`define MAP_OPEN2_END 32'hF200_05FF
`define MAP_RES2_END 32'hF7E0_FEFF
`define MAP_OPEN3_END 32'hF7E0_FFFF
`define MAP_RES3_END 32'hF7E1_7FFF
`define MAP_OPEN4_END 32'hF7E1_80FF
`define MAP_RES4_END 32'hF7E1_BFFF
`define MAP_OPEN5_END 32'hF7E1_EFFF
`define MAP_RES5_END 32'hF7E1_FCFF
`define MAP_OPEN6_END 32'hF7E1_FFFF
`define MAP_RES6_END 32'hF7FF_FFFF
`define MAP_OPEN7_END 32'hF800_01FF
`define MAP_RES7_END 32'hF800_03FF
`define MAP_OPEN8_END 32'hF800_04FF
`define MAP_RES8_END 32'hF87F_FBFF
`define MAP_OPEN9_END 32'hF87F_FFFF
`endif

// File: shared/mpc_pkg.sv
// Types shared by the memory protection checker files.
package mpc_pkg;
`include "mpc_map.svh"
   typedef enum logic [3:0] {
      TRAP_NONE,
      TRAP_PRIV,
      TRAP_RANGE_READ,
      TRAP_RANGE_WRITE,
      TRAP_RANGE_EXEC,
      TRAP_PAGE_MISS,
      TRAP_PAGE_READ,
      TRAP_PAGE_WRITE,
      TRAP_PAGE_EXEC,
      TRAP_BUS_ERROR
   } trap_type;

   typedef logic [`MODE_BITS-1:0] mode_type;
   typedef logic [31:0] addr_type;

   typedef struct packed {
      logic [`SETS-1:0][`RANGES-1:0][1:0][31:0] bound;
      logic [`SETS-1:0][`RANGES-1:0][`MODE_BITS-1:0] mode;
      logic [31:0] rdata;
      logic rvalid;
      logic [31:0] paddr;
      logic ok;
      trap_type trap;
      logic dbg;
      logic [31:0] dbg_addr;
   } state_type;
endpackage

// File: logic/range_match.sv
// Half-open address window comparator.
`timescale 1ns/10ps
module range_match (
   input wire logic [31:0] addr,
   input wire logic [31:0] lower,
   input wire logic [31:0] upper,
   output logic hit
);
   // RULE20 - half-open window test.
   assign hit = (addr >= lower) && (addr < upper);
endmodule

// File: logic/memory_protection_checker.sv
// Access checker: translation choice, range and page protection, traps.
// How it works
// RULE1 - Sixteen 256MB segments; the top four address bits give the segment.
// RULE2 - Upper-half addresses pass unchanged as physical in every mode.
// RULE3 - Lower half passes in physical mode, page-translated in virtual mode.
// RULE4 - Direct addresses use range checks, paged ones use page entry bits.
// RULE5 - Four protection sets; the set select input picks the active one.
// RULE6 - Each set has data ranges for data and code ranges for fetches.
// RULE7 - Data part holds four ranges, each with its own mode.
// RULE8 - Code part holds two ranges, each with its own mode.
// RULE9 - Each range has a bound pair; one mode word per set.
// RULE10 - Range modes deny read, write and fetch independently.
// RULE11 - Paged fetch needs the entry's exec permit bit.
// RULE12 - Paged write needs the entry's write permit bit.
// RULE13 - Paged read needs the entry's read permit bit.
// RULE14 - Virtual mode: lowest user level may not touch the upper half.
// RULE15 - Physical mode: lowest user level barred only from segments 14, 15.
// RULE16 - Such barred accesses raise the privileged address trap.
// RULE17 - A violation raises a trap class and blocks the access.
// RULE18 - Violations are flagged with their address to debug logic.
// RULE19 - Reserved system areas end in bus error, except marked areas.
// RULE20 - Hit means lower bound <= address < upper bound.
// RULE21 - No enabled covering range means a protection violation.
`timescale 1ns/10ps
`include "mpc_map.svh"
module memory_protection_checker
   import mpc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CFG_WE,
   input wire logic [6:0] CFG_ADDR,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   input wire logic [1:0] PROTECTION_SET_SELECT,
   input wire logic VIRT_MODE,
   input wire logic ACC_VALID,
   input wire logic [31:0] ACC_ADDR,
   input wire logic ACC_FETCH,
   input wire logic ACC_WRITE,
   input wire logic ACC_USER0,
   input wire logic PTE_VALID,
   input wire logic [19:0] PTE_FRAME,
   input wire logic PTE_EXEC_PERMIT_BIT,
   input wire logic PTE_WRITE_PERMIT_BIT,
   input wire logic PTE_READ_PERMIT_BIT,
   output logic RESP_VALID,
   output logic RESP_OK,
   output logic [31:0] RESP_PADDR,
   output trap_type TRAP_CLASS,
   output logic DEBUG_VIOLATION,
   output logic [31:0] DEBUG_ADDR
);
   state_type s_q;
   state_type s_d;
   logic [1:0] cfg_set;
   logic [4:0] cfg_item;
   logic [3:0] seg;
   logic upper_half;
   logic direct;
   logic priv;
   logic [31:0] paddr;
   logic [`RANGES-1:0] hit;
   logic [`RANGES-1:0] rd_ok;
   logic [`RANGES-1:0] wr_ok;
   logic [`RANGES-1:0] ex_ok;
   trap_type trap;

   assign cfg_set = CFG_ADDR[6:5];
   assign cfg_item = CFG_ADDR[4:0];

   // RULE1 - segment from top bits.
   assign seg = ACC_ADDR[`SEG_MSB:`SEG_LSB];
   assign upper_half = ACC_ADDR[`SEG_MSB];

   // RULE2 - upper half is always direct.
   // RULE3 - lower half direct only in physical mode.
   assign direct = upper_half || !VIRT_MODE;
   assign paddr = direct ? ACC_ADDR :
      {PTE_FRAME, ACC_ADDR[`PAGE_BITS-1:0]};

   // RULE14 - upper half barred in virtual mode.
   // RULE15 - only the top two segments in physical mode.
   assign priv = ACC_USER0 &&
      (VIRT_MODE ? upper_half : (seg >= `SEG_PRIV_FIRST));

   // One comparator per range of the active set keeps the path short; the
   // other sets are only storage until software switches the select.
   genvar g;
   generate
      for (g = 0; g < `RANGES; g++) begin : rng
         mode_type m;
         // RULE5 - active set chosen by select.
         assign m = s_q.mode[PROTECTION_SET_SELECT][g];
         // RULE9 - bound pair per range.
         range_match cmp (
            .addr(ACC_ADDR),
            .lower(s_q.bound[PROTECTION_SET_SELECT][g][0]),
            .upper(s_q.bound[PROTECTION_SET_SELECT][g][1]),
            .hit(hit[g])
         );
         if (g < `DATA_RANGES) begin : data
            // RULE7 - data ranges grant read and write.
            // RULE10 - read and write bits independent.
            assign rd_ok[g] = hit[g] && m[`MODE_EN] && m[`MODE_RD];
            assign wr_ok[g] = hit[g] && m[`MODE_EN] && m[`MODE_WR];
            assign ex_ok[g] = 1'b0;
         end else begin : code
            // RULE8 - code ranges grant fetch only.
            assign rd_ok[g] = 1'b0;
            assign wr_ok[g] = 1'b0;
            assign ex_ok[g] = hit[g] && m[`MODE_EN] && m[`MODE_EX];
         end
      end
   endgenerate

   // RULE19 - reserved areas of the system segment.
   function automatic logic reserved_area(input logic [31:0] a);
      logic r;
      r = 1'b0;
      if (a[`SEG_MSB:`SEG_LSB] != `SEG_SYSTEM) begin
         r = 1'b0;
      end else if (a <= `MAP_EXC_END) begin
         r = 1'b0;
      end else if (a <= `MAP_OPEN1_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES1_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN2_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES2_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN3_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES3_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN4_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES4_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN5_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES5_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN6_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES6_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN7_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES7_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN8_END) begin
         r = 1'b0;
      end else if (a <= `MAP_RES8_END) begin
         r = 1'b1;
      end else if (a <= `MAP_OPEN9_END) begin
         r = 1'b0;
      end else begin
         r = 1'b1;
      end
      return r;
   endfunction

   // Privilege first, then protection, then the map: a protection fault
   // must not be hidden behind a bus error on the same address.
   always_comb begin
      trap = TRAP_NONE;
      if (priv) begin
         // RULE16 - privileged address trap.
         trap = TRAP_PRIV;
      end else if (direct) begin
         // RULE4 - direct path uses ranges.
         // RULE6 - fetch checks code, data checks data.
         // RULE21 - nothing covering means denial.
         if (ACC_FETCH) begin
            if (!(|ex_ok)) begin
               trap = TRAP_RANGE_EXEC;
            end
         end else if (ACC_WRITE) begin
            if (!(|wr_ok)) begin
               trap = TRAP_RANGE_WRITE;
            end
         end else if (!(|rd_ok)) begin
            trap = TRAP_RANGE_READ;
         end
      end else if (!PTE_VALID) begin
         trap = TRAP_PAGE_MISS;
      end else if (ACC_FETCH) begin
         // RULE11 - exec permit bit.
         if (!PTE_EXEC_PERMIT_BIT) begin
            trap = TRAP_PAGE_EXEC;
         end
      end else if (ACC_WRITE) begin
         // RULE12 - write permit bit.
         if (!PTE_WRITE_PERMIT_BIT) begin
            trap = TRAP_PAGE_WRITE;
         end
      end else if (!PTE_READ_PERMIT_BIT) begin
         // RULE13 - read permit bit.
         trap = TRAP_PAGE_READ;
      end
      if (trap == TRAP_NONE && reserved_area(paddr)) begin
         trap = TRAP_BUS_ERROR;
      end
   end

   always_comb begin
      s_d = s_q;
      // A read in the same cycle as a write to that word returns the old
      // value; software that needs the new one reads again.
      s_d.rdata = 32'h0000_0000;
      if (cfg_item < `ITEM_BOUNDS) begin
         s_d.rdata = s_q.bound[cfg_set][cfg_item[3:1]][cfg_item[0]];
      end else if (cfg_item == `ITEM_MODE) begin
         s_d.rdata = {14'h0000, s_q.mode[cfg_set]};
      end
      if (CFG_WE) begin
         if (cfg_item < `ITEM_BOUNDS) begin
            s_d.bound[cfg_set][cfg_item[3:1]][cfg_item[0]] = CFG_WDATA;
         end else if (cfg_item == `ITEM_MODE) begin
            s_d.mode[cfg_set] = CFG_WDATA[17:0];
         end
      end
      s_d.rvalid = ACC_VALID;
      s_d.ok = 1'b0;
      s_d.trap = TRAP_NONE;
      s_d.dbg = 1'b0;
      if (ACC_VALID) begin
         s_d.paddr = paddr;
         s_d.trap = trap;
         // RULE17 - blocked when trapped.
         s_d.ok = (trap == TRAP_NONE);
         // RULE18 - debug flag and address.
         s_d.dbg = (trap != TRAP_NONE);
         if (trap != TRAP_NONE) begin
            s_d.dbg_addr = ACC_ADDR;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         s_q.bound <= {(`SETS*`RANGES*2){`BOUND_RST}};
         s_q.mode <= {`SETS{`MODE_RST}};
         s_q.rdata <= 32'h0000_0000;
         s_q.rvalid <= 1'b0;
         s_q.paddr <= 32'h0000_0000;
         s_q.ok <= 1'b0;
         s_q.trap <= TRAP_NONE;
         s_q.dbg <= 1'b0;
         s_q.dbg_addr <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign CFG_RDATA = s_q.rdata;
   assign RESP_VALID = s_q.rvalid;
   assign RESP_OK = s_q.ok;
   assign RESP_PADDR = s_q.paddr;
   assign TRAP_CLASS = s_q.trap;
   assign DEBUG_VIOLATION = s_q.dbg;
   assign DEBUG_ADDR = s_q.dbg_addr;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   sequence s_paged;
      ACC_VALID && VIRT_MODE && !ACC_ADDR[31] && !ACC_USER0 && PTE_VALID;
   endsequence
   sequence s_user_phys_top;
      ACC_VALID && ACC_USER0 && !VIRT_MODE && (ACC_ADDR[31:29] == 3'h7);
   endsequence

   a_upper_direct: assert property ( // RULE2
      ACC_VALID && ACC_ADDR[31] |=> RESP_PADDR == $past(ACC_ADDR))
      else $error("upper half address was not passed unchanged");
   a_phys_pass: assert property ( // RULE3
      ACC_VALID && !VIRT_MODE |=> RESP_PADDR == $past(ACC_ADDR))
      else $error("physical mode address was altered");
   a_page_frame: assert property ( // RULE3
      s_paged |=> RESP_PADDR[31:12] == $past(PTE_FRAME) &&
         RESP_PADDR[11:0] == $past(ACC_ADDR[11:0]))
      else $error("page translation result is wrong");
   a_page_exec: assert property ( // RULE11
      s_paged and (ACC_FETCH && !PTE_EXEC_PERMIT_BIT)
         |=> TRAP_CLASS == TRAP_PAGE_EXEC && !RESP_OK)
      else $error("fetch from non executable page not trapped");
   a_page_write: assert property ( // RULE12
      s_paged and (!ACC_FETCH && ACC_WRITE && !PTE_WRITE_PERMIT_BIT)
         |=> TRAP_CLASS == TRAP_PAGE_WRITE)
      else $error("write to read only page not trapped");
   a_page_read: assert property ( // RULE13
      s_paged and (!ACC_FETCH && !ACC_WRITE && !PTE_READ_PERMIT_BIT)
         |=> TRAP_CLASS == TRAP_PAGE_READ)
      else $error("read from unreadable page not trapped");
   a_user_upper: assert property ( // RULE14
      ACC_VALID && ACC_USER0 && VIRT_MODE && ACC_ADDR[31]
         |=> TRAP_CLASS == TRAP_PRIV ##1 !DEBUG_VIOLATION || $past(ACC_VALID))
      else $error("user upper half access not trapped");
   a_phys_top: assert property ( // RULE15
      s_user_phys_top |=> TRAP_CLASS == TRAP_PRIV && DEBUG_VIOLATION)
      else $error("user access to top segments not trapped");
   a_phys_low: assert property ( // RULE15
      ACC_VALID && ACC_USER0 && !VIRT_MODE && ACC_ADDR[31:29] != 3'h7
         |=> TRAP_CLASS != TRAP_PRIV)
      else $error("privileged trap raised in physical low segment");
   a_trap_block: assert property ( // RULE17
      RESP_VALID |-> RESP_OK == (TRAP_CLASS == TRAP_NONE))
      else $error("trapped access reported as completed");
   a_debug_addr: assert property ( // RULE18
      ACC_VALID ##1 TRAP_CLASS != TRAP_NONE
         |-> DEBUG_VIOLATION && DEBUG_ADDR == $past(ACC_ADDR))
      else $error("violation not flagged to debug with its address");
   a_cfg_read: assert property ( // RULE9
      CFG_WE && !$past(CFG_WE) ##1 CFG_ADDR == $past(CFG_ADDR) && !CFG_WE
         && CFG_ADDR[4:0] < 5'h0C |=> CFG_RDATA == $past(CFG_WDATA, 2))
      else $error("bound register did not read back");

   // Enable bits of ranges 0 to 3 and of ranges 4 and 5 in a mode word.
   sequence s_closed_data;
      ACC_VALID && !ACC_USER0 && !VIRT_MODE && !ACC_FETCH &&
         (s_q.mode[PROTECTION_SET_SELECT] & 18'h0_0249) == 18'h0_0000;
   endsequence
   sequence s_closed_fetch;
      ACC_VALID && !ACC_USER0 && !VIRT_MODE && ACC_FETCH &&
         (s_q.mode[PROTECTION_SET_SELECT] & 18'h0_9000) == 18'h0_0000;
   endsequence

   a_read_closed: assert property ( // RULE21
      s_closed_data and !ACC_WRITE |=> TRAP_CLASS == TRAP_RANGE_READ)
      else $error("read with no enabled data range was not trapped");
   a_write_closed: assert property ( // RULE21
      s_closed_data and ACC_WRITE |=> TRAP_CLASS == TRAP_RANGE_WRITE)
      else $error("write with no enabled data range was not trapped");
   a_fetch_closed: assert property ( // RULE8
      s_closed_fetch |=> TRAP_CLASS == TRAP_RANGE_EXEC && !RESP_OK)
      else $error("fetch with no enabled code range was not trapped");
   a_every_answer: assert property ( // RULE17
      ACC_VALID |=> RESP_VALID)
      else $error("access was not answered in the next cycle");
   a_idle_quiet: assert property ( // RULE18
      !ACC_VALID |=> !RESP_VALID && !DEBUG_VIOLATION &&
         TRAP_CLASS == TRAP_NONE)
      else $error("response or debug flag without an access");
   a_reserved_top: assert property ( // RULE19
      ACC_VALID && ACC_ADDR[31:24] == 8'hFF |=> !RESP_OK)
      else $error("access to the reserved top area completed");
endmodule

// File: tb/core_access_model.sv
// Core side model that presents load, store and fetch requests.
`timescale 1ns/10ps
module core_access_model (
   output logic acc_valid,
   output logic [31:0] acc_addr,
   output logic acc_fetch,
   output logic acc_write,
   output logic acc_user0,
   output logic pte_valid,
   output logic [19:0] pte_frame,
   output logic pte_exec,
   output logic pte_write,
   output logic pte_read
);
   initial begin
      {acc_valid, acc_addr, acc_fetch, acc_write, acc_user0} = '0;
      {pte_valid, pte_frame, pte_exec, pte_write, pte_read} = '0;
   end
   // Called just after a rising edge; the request holds until the next call.
   task automatic drive(logic [31:0] a, logic f, logic w, logic u,
                        logic pv, logic [19:0] fr, logic [2:0] pm);
      acc_valid <= 1'b1;
      acc_addr <= a;
      {acc_fetch, acc_write, acc_user0, pte_valid} <= {f, w, u, pv};
      pte_frame <= fr;
      {pte_exec, pte_write, pte_read} <= pm;
   endtask
   // Released address, access and frame fields are inverted so a stale value is never trusted.
   task automatic rest();
      acc_valid <= 1'b0;
      acc_addr <= ~acc_addr;
      {acc_fetch, acc_write, acc_user0} <= ~{acc_fetch, acc_write, acc_user0};
      pte_frame <= ~pte_frame;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench of the memory protection checker.
`timescale 1ns/10ps
`include "mpc_map.svh"
module testbench;
   import mpc_pkg::*;
   typedef struct {
      trap_type t;
      logic [31:0] va;
      logic [31:0] pa;
      int due;
   } note_type;
   logic CLOCK = 1'b0;
   logic NRST = 1'b0;
   logic CFG_WE = 1'b0;
   logic [6:0] CFG_ADDR = 7'h00;
   logic [31:0] CFG_WDATA = 32'h0000_0000;
   logic [1:0] PROTECTION_SET_SELECT = 2'h0;
   logic VIRT_MODE = 1'b0;
   wire logic ACC_VALID, ACC_FETCH, ACC_WRITE, ACC_USER0, PTE_VALID;
   wire logic PTE_EXEC_PERMIT_BIT, PTE_WRITE_PERMIT_BIT, PTE_READ_PERMIT_BIT;
   wire logic [31:0] ACC_ADDR;
   wire logic [19:0] PTE_FRAME;
   logic [31:0] CFG_RDATA, RESP_PADDR, DEBUG_ADDR;
   logic RESP_VALID, RESP_OK, DEBUG_VIOLATION;
   trap_type TRAP_CLASS;
   logic [31:0] bnd [4][6][2] = '{default: 32'h0000_0000};
   logic [17:0] md [4] = '{default: 18'h0_0000};
   logic [31:0] rsv [9][2];
   note_type q [$];
   note_type n;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   always #2 CLOCK = ~CLOCK;
   always @(posedge CLOCK) cyc <= cyc + 1;
   memory_protection_checker i_dut (.CLOCK(CLOCK), .NRST(NRST),
      .CFG_WE(CFG_WE), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
      .CFG_RDATA(CFG_RDATA), .PROTECTION_SET_SELECT(PROTECTION_SET_SELECT),
      .VIRT_MODE(VIRT_MODE), .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
      .ACC_FETCH(ACC_FETCH), .ACC_WRITE(ACC_WRITE), .ACC_USER0(ACC_USER0),
      .PTE_VALID(PTE_VALID), .PTE_FRAME(PTE_FRAME),
      .PTE_EXEC_PERMIT_BIT(PTE_EXEC_PERMIT_BIT),
      .PTE_WRITE_PERMIT_BIT(PTE_WRITE_PERMIT_BIT),
      .PTE_READ_PERMIT_BIT(PTE_READ_PERMIT_BIT), .RESP_VALID(RESP_VALID),
      .RESP_OK(RESP_OK), .RESP_PADDR(RESP_PADDR), .TRAP_CLASS(TRAP_CLASS),
      .DEBUG_VIOLATION(DEBUG_VIOLATION), .DEBUG_ADDR(DEBUG_ADDR));
   core_access_model i_core (.acc_valid(ACC_VALID), .acc_addr(ACC_ADDR),
      .acc_fetch(ACC_FETCH), .acc_write(ACC_WRITE), .acc_user0(ACC_USER0),
      .pte_valid(PTE_VALID), .pte_frame(PTE_FRAME),
      .pte_exec(PTE_EXEC_PERMIT_BIT), .pte_write(PTE_WRITE_PERMIT_BIT),
      .pte_read(PTE_READ_PERMIT_BIT));
   initial rsv = '{'{`MAP_OPEN1_END + 32'h0000_0001, `MAP_RES1_END},
      '{`MAP_OPEN2_END + 32'h0000_0001, `MAP_RES2_END},
      '{`MAP_OPEN3_END + 32'h0000_0001, `MAP_RES3_END},
      '{`MAP_OPEN4_END + 32'h0000_0001, `MAP_RES4_END},
      '{`MAP_OPEN5_END + 32'h0000_0001, `MAP_RES5_END},
      '{`MAP_OPEN6_END + 32'h0000_0001, `MAP_RES6_END},
      '{`MAP_OPEN7_END + 32'h0000_0001, `MAP_RES7_END},
      '{`MAP_OPEN8_END + 32'h0000_0001, `MAP_RES8_END},
      '{`MAP_OPEN9_END + 32'h0000_0001, 32'hFFFF_FFFF}};
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("Counts: %0d checks, %0d mismatches", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   function automatic note_type exp_of(logic [31:0] a, logic f, logic w,
      logic u, logic v, logic [1:0] s, logic pv, logic [19:0] fr,
      logic [2:0] pm);
      note_type e;
      logic hit;
      int b;
      e = '{TRAP_NONE, a, a, cyc + 2};
      hit = 1'b0;
      b = (w && !f) ? 2 : 1;
      if (u && (v ? a[31] : a[31:29] == 3'h7)) e.t = TRAP_PRIV;
      else if (v && !a[31]) begin
         e.pa = {fr, a[11:0]};
         if (!pv) e.t = TRAP_PAGE_MISS;
         else if (f) e.t = pm[2] ? TRAP_NONE : TRAP_PAGE_EXEC;
         else if (w) e.t = pm[1] ? TRAP_NONE : TRAP_PAGE_WRITE;
         else e.t = pm[0] ? TRAP_NONE : TRAP_PAGE_READ;
      end else begin
         for (int r = 0; r < 6; r++)
            if ((r > 3) == f && md[s][3*r] && md[s][3*r+b] &&
                a >= bnd[s][r][0] && a < bnd[s][r][1]) hit = 1'b1;
         if (!hit)
            e.t = f ? TRAP_RANGE_EXEC : w ? TRAP_RANGE_WRITE : TRAP_RANGE_READ;
      end
      // reserved areas, judged on the physical address of both paths.
      if (e.t == TRAP_NONE)
         for (int i = 0; i < 9; i++)
            if (e.pa >= rsv[i][0] && e.pa <= rsv[i][1]) e.t = TRAP_BUS_ERROR;
      return e;
   endfunction
   task automatic acc(logic [31:0] a, logic f, logic w, logic u, logic v,
      logic [1:0] s, logic pv, logic [19:0] fr, logic [2:0] pm);
      @(posedge CLOCK);
      PROTECTION_SET_SELECT <= s;
      VIRT_MODE <= v;
      i_core.drive(a, f, w, u, pv, fr, pm);
      q.push_back(exp_of(a, f, w, u, v, s, pv, fr, pm));
   endtask
   task automatic cfg_wr(logic [1:0] s, logic [4:0] it, logic [31:0] d);
      @(posedge CLOCK);
      i_core.rest();
      {CFG_WE, CFG_ADDR, CFG_WDATA} <= {1'b1, s, it, d};
      if (it < 12) bnd[s][it[3:1]][it[0]] = d;
      else if (it == 12) md[s] = d[17:0];
      @(posedge CLOCK);
      CFG_WE <= 1'b0;
   endtask
   task automatic cfg_rd(logic [1:0] s, logic [4:0] it);
      @(posedge CLOCK);
      i_core.rest();
      CFG_ADDR <= {s, it};
      @(posedge CLOCK);
      @(negedge CLOCK);
      chk("cfg_rdata", CFG_RDATA, it < 12 ? bnd[s][it[3:1]][it[0]] :
          it == 12 ? {14'h0000, md[s]} : 32'h0000_0000);
   endtask
   always @(negedge CLOCK) begin
      if (RESP_VALID === 1'b1 && q.size() > 0) begin
         n = q.pop_front();
         chk("latency", cyc, n.due);
         chk("trap", {28'h0, TRAP_CLASS}, {28'h0, n.t});
         chk("ok", RESP_OK, n.t == TRAP_NONE);
         chk("dbg", DEBUG_VIOLATION, n.t != TRAP_NONE);
         if (n.t != TRAP_NONE) chk("dbg_addr", DEBUG_ADDR, n.va);
         else chk("paddr", RESP_PADDR, n.pa);
      end else begin
         chk("resp_valid", RESP_VALID, 32'h0000_0000);
         chk("idle_dbg", DEBUG_VIOLATION, 32'h0000_0000);
      end
   end
   initial begin
      repeat (100000) @(posedge CLOCK);
      err_total++;
      close_out();
   end
   initial begin
      logic [31:0] r;
      void'($urandom(41523));
      repeat (2) @(posedge CLOCK);
      NRST <= 1'b1;
      for (int k = 0; k < 3; k++)
         acc(32'h2000_0000, k == 2, k == 1, 0, 0, 2'h0, 0, 20'h0_0000, 3'h0);
      cfg_rd(2'h1, 5'h03);
      $display("test reset_state done");
      // Different windows per set so a wrong set select shows up.
      for (int s = 0; s < 4; s++) begin
         for (int g = 0; g < 3; g++) begin
            cfg_wr(s, 2*g, 32'h2000_0000 * g + 32'h0100_0000 * s);
            cfg_wr(s, 2*g + 1, bnd[s][g][0] + 32'h1800_0000);
         end
         cfg_wr(s, 5'h06, 32'hF000_0000);
         cfg_wr(s, 5'h07, 32'hFFFF_FFFF);
         cfg_wr(s, 5'h08, 32'h0100_0000 * s);
         cfg_wr(s, 5'h09, 32'h9000_0000);
         cfg_wr(s, 5'h0A, 32'hC000_0000);
         cfg_wr(s, 5'h0B, 32'hFFFF_FFFF);
         r = $urandom;
         cfg_wr(s, 5'h0C, {14'h0000, r[17:0]});
         for (int it = 0; it < 15; it++) cfg_rd(s, it[4:0]);
         cfg_rd(s, 5'h1F);
      end
      $display("test config done");
      for (int s = 0; s < 4; s++)
         for (int g = 0; g < 6; g++)
            for (int k = 0; k < 4; k++)
               acc(bnd[s][g][k[1]] - k[0], g > 3, s[0], 0, 0, s, 0,
                   20'h0_0000, 3'h0);
      $display("test bounds done");
      for (int m = 0; m < 8; m++) begin
         cfg_wr(2'h0, 5'h0C, {14'h0000, {6{m[2:0]}}});
         for (int k = 0; k < 3; k++)
            acc(32'h0080_0000, k == 2, k == 1, 0, 0, 2'h0, 0, 20'h0_0000,
                3'h0);
      end
      $display("test modes done");
      for (int m = 0; m < 9; m++)
         for (int k = 0; k < 3; k++)
            acc(32'h1234_5678 + m, k == 2, k == 1, m[0], 1, 2'h3, m < 8,
                m[0] ? 20'hFFFF_0 : 20'hABCD_E, m[2:0]);
      $display("test pages done");
      for (int k = 0; k < 10; k++)
         acc(k < 5 ? 32'hE000_0010 + 32'h0800_0000 * k : 32'h7FFF_FFF0 +
             32'h1000_0000 * (k - 5), 0, 0, 1, k[0], 2'h1, 1, 20'h0_0001,
             3'h7);
      $display("test privilege done");
      cfg_wr(2'h0, 5'h0C, 32'h0003_FFFF);
      for (int i = 0; i < 9; i++)
         for (int k = 0; k < 3; k++)
            acc(k == 2 ? rsv[i][0] - 32'h0000_0001 : rsv[i][k], 0, 0, 0, 0,
                2'h0, 0, 20'h0_0000, 3'h0);
      acc(32'hF03F_FFFF, 0, 0, 0, 0, 2'h0, 0, 20'h0_0000, 3'h0);
      $display("test bus_error done");
      for (int k = 0; k < 400; k++) begin
         r = $urandom;
         acc(r[4] ? bnd[r[6:5]][r[9:7] % 6][r[10]] + r[12:11] - 32'h2 :
             $urandom, r[0], r[1], r[2], r[3], r[6:5], r[13], $urandom,
             r[16:14]);
      end
      cfg_rd(2'h0, 5'h00);
      $display("test random done");
      repeat (3) @(posedge CLOCK);
      NRST <= 1'b0;
      repeat (2) @(posedge CLOCK);
      NRST <= 1'b1;
      bnd = '{default: 32'h0000_0000};
      md = '{default: 18'h0_0000};
      cfg_rd(2'h2, 5'h0C);
      acc(32'h0000_0100, 0, 1, 0, 0, 2'h0, 0, 20'h0_0000, 3'h0);
      cfg_rd(2'h0, 5'h01);
      repeat (3) @(posedge CLOCK);
      chk("pending", q.size(), 32'h0000_0000);
      $display("test second_reset done");
      close_out();
   end
endmodule
